// ### hw/pcacr_channel.sv
`timescale 1ns/10ps
module pcacr_channel
  import pcacr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic [7:0] i_wdata,
  input wire logic i_alias_sel,
  input wire logic i_ecom_load,
  input wire logic i_ecom_value,
  input wire logic [15:0] i_counter,
  output logic [15:0] o_capture,
  output logic [15:0] o_reload,
  output logic [15:0] o_view,
  output logic o_ecom,
  output logic o_match
);

  pcacr_ch_st_t st_r;
  pcacr_ch_st_t st_nxt;

  // byte writes, enable side effects and compare
  always_comb begin
    st_nxt = st_r;
    if (i_wr_lo) begin
      if (i_alias_sel) begin
        st_nxt.reload[7:0] = i_wdata;
      end else begin
        st_nxt.capture[7:0] = i_wdata;
      end
      st_nxt.ecom = 1'b0;
    end else if (i_wr_hi) begin
      if (i_alias_sel) begin
        st_nxt.reload[15:8] = i_wdata;
      end else begin
        st_nxt.capture[15:8] = i_wdata;
      end
      st_nxt.ecom = 1'b1;
    end else if (i_ecom_load) begin
      st_nxt.ecom = i_ecom_value;
    end
    st_nxt.match = st_r.ecom && (i_counter == st_r.capture);
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign o_capture = st_r.capture;
  assign o_reload = st_r.reload;
  assign o_view = i_alias_sel ? st_r.reload : st_r.capture;
  assign o_ecom = st_r.ecom;
  assign o_match = st_r.match;

  // checks on the byte side effects
  a_low_clears_en: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && i_wr_lo |=> !o_ecom
  ) else $error("low byte write left enable set");

  a_high_sets_en: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && i_wr_hi |=> o_ecom
  ) else $error("high byte write left enable clear");

  a_alias_steer: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && i_wr_lo && i_alias_sel |=>
      o_reload[7:0] == $past(i_wdata) && o_capture == $past(o_capture)
  ) else $error("aliased write reached the wrong value");

  a_match_cause: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(o_match) |->
      $past(o_ecom) && $past(i_counter) == $past(o_capture)
  ) else $error("match without enable or equal count");

  c_alias_write: cover property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && i_wr_hi && i_alias_sel
  );

endmodule : pcacr_channel

// ### hw/pcacr_pkg.sv
package pcacr_pkg;

  localparam int PCACR_NCH = 6;
  // counter byte addresses
  localparam logic [7:0] PCACR_ADDR_CNT_LO = 8'hF9;
  localparam logic [7:0] PCACR_ADDR_CNT_HI = 8'hFA;
  // module byte addresses, index 0 is module 6 up to index 5 module 11
  localparam logic [5:0][7:0] PCACR_ADDR_CPL = {
    8'hCE, 8'hFD, 8'hED, 8'hEB, 8'hE9, 8'hFB
  };
  localparam logic [5:0][7:0] PCACR_ADDR_CPH = {
    8'hCF, 8'hFE, 8'hEE, 8'hEC, 8'hEA, 8'hFC
  };
  // reset values and counter step
  localparam logic [7:0] PCACR_BYTE_RST = 8'h00;
  localparam logic [15:0] PCACR_WORD_RST = 16'h0000;
  localparam logic [15:0] PCACR_CNT_STEP = 16'h0001;
  localparam logic PCACR_ECOM_RST = 1'b0;
  localparam logic [7:0] PCACR_UNMAPPED_RD = 8'h00;

  // state of one capture/compare module
  typedef struct packed {
    logic [15:0] capture;
    logic [15:0] reload;
    logic ecom;
    logic match;
  } pcacr_ch_st_t;

  // state of the counter and read path
  typedef struct packed {
    logic [15:0] counter;
    logic [7:0] snapshot;
    logic [7:0] rdata;
  } pcacr_top_st_t;

endpackage : pcacr_pkg

// ### hw/pcacr_regs.sv
`timescale 1ns/10ps
module pcacr_regs
  import pcacr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic i_sfr_page_sel,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_count_tick,
  input wire logic i_auto_reload_select,
  input wire logic [5:0] i_pwm_short_mode,
  input wire logic [5:0] i_ecom_load,
  input wire logic [5:0] i_ecom_value,
  output logic [15:0] o_counter,
  output logic [5:0] o_comparator_enable,
  output logic [5:0] o_match,
  output logic [5:0][15:0] o_capture_value,
  output logic [5:0][15:0] o_auto_reload
);

  logic [1:0] rst_sync_r;
  logic rst_n;
  pcacr_top_st_t st_r;
  pcacr_top_st_t st_nxt;
  logic wr_ok;
  logic rd_ok;
  logic hit_cnt_lo;
  logic hit_cnt_hi;
  logic [5:0] hit_lo;
  logic [5:0] hit_hi;
  logic [5:0] alias_sel;
  logic [5:0][15:0] view;
  logic any_hit;
  logic [15:0] cnt_inc;

  // reset release through two flops
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // access qualification and address decode
  assign wr_ok = i_sfr_wr && i_sfr_page_sel;
  assign rd_ok = i_sfr_rd && i_sfr_page_sel;
  assign hit_cnt_lo = (i_sfr_addr == PCACR_ADDR_CNT_LO);
  assign hit_cnt_hi = (i_sfr_addr == PCACR_ADDR_CNT_HI);

  // helpers for the checks below
  assign any_hit = hit_cnt_lo || hit_cnt_hi || (|hit_lo) || (|hit_hi);
  assign cnt_inc = st_r.counter + PCACR_CNT_STEP;

  // one capture/compare module per channel
  for (genvar g = 0; g < PCACR_NCH; g++) begin : g_ch
    assign hit_lo[g] = (i_sfr_addr == PCACR_ADDR_CPL[g]);
    assign hit_hi[g] = (i_sfr_addr == PCACR_ADDR_CPH[g]);
    // alias only for 9 to 11-bit pwm under the select bit
    assign alias_sel[g] = i_auto_reload_select && i_pwm_short_mode[g];
    pcacr_channel u_ch (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .i_clk_en(i_clk_en),
      .i_wr_lo(wr_ok && hit_lo[g]),
      .i_wr_hi(wr_ok && hit_hi[g]),
      .i_wdata(i_sfr_wdata),
      .i_alias_sel(alias_sel[g]),
      .i_ecom_load(i_ecom_load[g]),
      .i_ecom_value(i_ecom_value[g]),
      .i_counter(st_r.counter),
      .o_capture(o_capture_value[g]),
      .o_reload(o_auto_reload[g]),
      .o_view(view[g]),
      .o_ecom(o_comparator_enable[g]),
      .o_match(o_match[g])
    );
  end

  // counter, snapshot and registered read data
  always_comb begin
    st_nxt = st_r;
    if (i_count_tick) begin
      st_nxt.counter = st_r.counter + PCACR_CNT_STEP;
    end
    if (wr_ok && hit_cnt_lo) begin
      st_nxt.counter[7:0] = i_sfr_wdata;
    end
    if (wr_ok && hit_cnt_hi) begin
      st_nxt.counter[15:8] = i_sfr_wdata;
    end
    if (rd_ok) begin
      st_nxt.rdata = PCACR_UNMAPPED_RD;
      if (hit_cnt_lo) begin
        st_nxt.rdata = st_r.counter[7:0];
        st_nxt.snapshot = st_r.counter[15:8];
      end else if (hit_cnt_hi) begin
        st_nxt.rdata = st_r.snapshot;
      end
      for (int k = 0; k < PCACR_NCH; k++) begin
        if (hit_lo[k]) begin
          st_nxt.rdata = view[k][7:0];
        end
        if (hit_hi[k]) begin
          st_nxt.rdata = view[k][15:8];
        end
      end
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign o_sfr_rdata = st_r.rdata;
  assign o_counter = st_r.counter;

  // snapshot loads only on a low byte read
  a_snap_on_low: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && rd_ok && hit_cnt_lo |=>
      st_r.snapshot == $past(st_r.counter[15:8])
  ) else $error("snapshot not loaded on low byte read");

  a_snap_holds: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    !(i_clk_en && rd_ok && hit_cnt_lo) |=> $stable(st_r.snapshot)
  ) else $error("snapshot changed without low byte read");

  // low then high read returns the counter as it was at the low read
  a_pair_read: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (i_clk_en && rd_ok && hit_cnt_lo) ##1
      (i_clk_en && rd_ok && hit_cnt_hi) |=>
      o_sfr_rdata == $past(st_r.counter[15:8], 2)
  ) else $error("high byte read not from snapshot");

  a_cnt_lo_wr: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && wr_ok && hit_cnt_lo |=>
      o_counter[7:0] == $past(i_sfr_wdata)
  ) else $error("counter low byte write lost");

  a_cnt_hi_wr: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && wr_ok && hit_cnt_hi |=>
      o_counter[15:8] == $past(i_sfr_wdata)
  ) else $error("counter high byte write lost");

  a_cnt_lo_rd: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && rd_ok && hit_cnt_lo |=>
      o_sfr_rdata == $past(o_counter[7:0])
  ) else $error("counter low byte read wrong");

  a_cap_lo_rd: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && rd_ok && hit_lo[0] && !alias_sel[0] |=>
      o_sfr_rdata == $past(o_capture_value[0][7:0])
  ) else $error("module low byte read wrong");

  a_cap_hi_wr: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && wr_ok && hit_hi[5] && !alias_sel[5] |=>
      o_capture_value[5][15:8] == $past(i_sfr_wdata)
  ) else $error("module high byte write lost");

  a_cnt_runs: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && i_count_tick && !(wr_ok && (hit_cnt_lo || hit_cnt_hi))
      |=> o_counter == 16'($past(o_counter) + PCACR_CNT_STEP)
  ) else $error("counter did not advance");

  // a low byte write in a tick cycle keeps the incremented high byte
  a_tick_lo_wr: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && i_count_tick && wr_ok && hit_cnt_lo |=>
      o_counter[15:8] == $past(cnt_inc[15:8])
  ) else $error("tick lost beside counter low byte write");

  // high byte read returns the snapshot
  a_cnt_hi_rd: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && rd_ok && hit_cnt_hi |=>
      o_sfr_rdata == $past(st_r.snapshot)
  ) else $error("counter high byte read not from snapshot");

  a_cap_hi_rd: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && rd_ok && hit_hi[0] && !alias_sel[0] |=>
      o_sfr_rdata == $past(o_capture_value[0][15:8])
  ) else $error("module high byte read wrong");

  a_cap_lo_wr: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && wr_ok && hit_lo[2] && !alias_sel[2] |=>
      o_capture_value[2][7:0] == $past(i_sfr_wdata)
  ) else $error("module low byte write lost");

  // aliased bytes reach the auto-reload value
  a_alias_rd: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && rd_ok && hit_lo[1] && alias_sel[1] |=>
      o_sfr_rdata == $past(o_auto_reload[1][7:0])
  ) else $error("aliased low byte read wrong");

  a_alias_rd_hi: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && rd_ok && hit_hi[5] && alias_sel[5] |=>
      o_sfr_rdata == $past(o_auto_reload[5][15:8])
  ) else $error("aliased high byte read wrong");

  a_alias_wr_hi: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && wr_ok && hit_hi[1] && alias_sel[1] |=>
      o_auto_reload[1][15:8] == $past(i_sfr_wdata) &&
      o_capture_value[1] == $past(o_capture_value[1])
  ) else $error("aliased high byte write reached the wrong value");

  // enable side effects on every module
  a_lo_clears_all: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && wr_ok && (|hit_lo) |=>
      (o_comparator_enable & $past(hit_lo)) == 6'h00
  ) else $error("low byte write left an enable set");

  a_hi_sets_all: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && wr_ok && (|hit_hi) |=>
      (o_comparator_enable & $past(hit_hi)) == $past(hit_hi)
  ) else $error("high byte write left an enable clear");

  // compare follows the enable
  a_match_needs_en: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    $past(i_clk_en) && o_match[0] |->
      $past(o_comparator_enable[0])
  ) else $error("match with enable clear");

  a_match_when_eq: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && o_comparator_enable[0] &&
      o_counter == o_capture_value[0] |=> o_match[0]
  ) else $error("no match with enable set and equal count");

  // read path and gating
  a_unmapped_rd: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && rd_ok && !any_hit |=> o_sfr_rdata == PCACR_UNMAPPED_RD
  ) else $error("unmapped read returned data");

  a_rdata_holds: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    !(i_clk_en && rd_ok) |=> $stable(o_sfr_rdata)
  ) else $error("read data changed without a read");

  a_freeze: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    !i_clk_en |=> $stable(o_counter) && $stable(o_capture_value) &&
      $stable(o_auto_reload) && $stable(o_comparator_enable)
  ) else $error("state moved while the clock enable was low");

  a_page_gate: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_clk_en && !i_sfr_page_sel && !i_count_tick |=>
      $stable(o_counter) && $stable(o_capture_value) &&
      $stable(o_auto_reload)
  ) else $error("write landed with the page deselected");

  // main scenarios
  c_pair_read: cover property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (rd_ok && hit_cnt_lo) ##1 (rd_ok && hit_cnt_hi)
  );

  c_update_seq: cover property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (wr_ok && hit_lo[0]) ##[1:4] (wr_ok && hit_hi[0])
  );

  c_match: cover property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    o_match[0]
  );

endmodule : pcacr_regs

// ### tb/testbench.sv
`timescale 1ns/10ps
// compare and count; a mismatch prints at once
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); \
  end \
end
module testbench;
  import pcacr_pkg::*;
  typedef struct {
    logic [7:0] lo;
    logic [7:0] hi;
    logic [15:0] val;
  } pcacr_row_t;
  logic i_ref_clk, i_arst_n, i_clk_en, i_sfr_page_sel;
  logic i_sfr_wr, i_sfr_rd, i_count_tick, i_auto_reload_select;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, v;
  logic [5:0] i_pwm_short_mode, i_ecom_load, i_ecom_value;
  logic [5:0] o_comparator_enable, o_match;
  logic [15:0] o_counter;
  logic [5:0][15:0] o_capture_value, o_auto_reload;
  int n_errors = 0;
  int cmp_count = 0;
  // module byte addresses and written value, row g is module 6+g
  pcacr_row_t rows [6] = '{'{8'hFB, 8'hFC, 16'hC020},
    '{8'hE9, 8'hEA, 16'hC121}, '{8'hEB, 8'hEC, 16'hC222},
    '{8'hED, 8'hEE, 16'hC323}, '{8'hFD, 8'hFE, 16'hC424},
    '{8'hCE, 8'hCF, 16'hC525}};

  pcacr_regs u_pcacr_regs (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
    .i_sfr_page_sel(i_sfr_page_sel), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_count_tick(i_count_tick),
    .i_auto_reload_select(i_auto_reload_select),
    .i_pwm_short_mode(i_pwm_short_mode), .i_ecom_load(i_ecom_load),
    .i_ecom_value(i_ecom_value), .o_counter(o_counter),
    .o_comparator_enable(o_comparator_enable), .o_match(o_match),
    .o_capture_value(o_capture_value), .o_auto_reload(o_auto_reload)
  );

  // 125 MHz reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  // one write strobe, ends after the taking edge has landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_sfr_wr <= 1'b0;
    @(negedge i_ref_clk);
  endtask : wr

  // one read strobe, data taken once the read edge has passed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_sfr_rd <= 1'b0;
    @(negedge i_ref_clk);
    d = o_sfr_rdata;
  endtask : rd

  // counts, verdict and end of run
  task automatic finish_test;
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // guard against a hang
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    n_errors++;
    finish_test();
  end

  // main sequence
  initial begin
    i_arst_n = 1'b0;
    i_clk_en = 1'b1;
    i_sfr_page_sel = 1'b1;
    i_sfr_addr = 8'h00;
    i_sfr_wdata = 8'h00;
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
    i_count_tick = 1'b0;
    i_auto_reload_select = 1'b0;
    i_pwm_short_mode = 6'h00;
    i_ecom_load = 6'h00;
    i_ecom_value = 6'h00;
    repeat (20) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    // reset values
    `CHK("counter", 16'h0000, o_counter)
    `CHK("enables", 6'h00, o_comparator_enable)
    rd(8'hF9, v);
    `CHK("cnt_lo", 8'h00, v)
    rd(8'hFA, v);
    `CHK("cnt_hi", 8'h00, v)
    // table: high then low byte per module, then read back
    for (int g = 0; g < 6; g++) begin
      rd(rows[g].lo, v);
      `CHK("cap_lo_rst", 8'h00, v)
      wr(rows[g].hi, rows[g].val[15:8]);
      `CHK("ecom_hi", 1'b1, o_comparator_enable[g])
      wr(rows[g].lo, rows[g].val[7:0]);
      `CHK("ecom_lo", 1'b0, o_comparator_enable[g])
      `CHK("cap", rows[g].val, o_capture_value[g])
      rd(rows[g].lo, v);
      `CHK("rd_lo", rows[g].val[7:0], v)
      rd(rows[g].hi, v);
      `CHK("rd_hi", rows[g].val[15:8], v)
    end
    // compare runs only while the enable is set
    wr(8'hF9, 8'h20);
    wr(8'hFA, 8'hC0);
    wr(8'hFC, 8'hC0);
    @(negedge i_ref_clk);
    `CHK("match_on", 2'b01, o_match[1:0])
    wr(8'hFB, 8'h20);
    @(negedge i_ref_clk);
    `CHK("match_off", 1'b0, o_match[0])
    // snapshot of the high byte follows low byte reads only
    rd(8'hF9, v);
    `CHK("snap_lo", 8'h20, v)
    wr(8'hFA, 8'h55);
    rd(8'hFA, v);
    `CHK("snap_old", 8'hC0, v)
    rd(8'hF9, v);
    rd(8'hFA, v);
    `CHK("snap_new", 8'h55, v)
    // four counting edges
    @(posedge i_ref_clk);
    i_count_tick <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    i_count_tick <= 1'b0;
    @(negedge i_ref_clk);
    `CHK("count", 16'h5524, o_counter)
    // module 7 in short pwm with auto-reload selected
    @(posedge i_ref_clk);
    i_auto_reload_select <= 1'b1;
    i_pwm_short_mode <= 6'h02;
    wr(8'hE9, 8'h5A);
    wr(8'hEA, 8'hA5);
    `CHK("reload", 16'hA55A, o_auto_reload[1])
    `CHK("cap_kept", 16'hC121, o_capture_value[1])
    `CHK("alias_ecom", 1'b1, o_comparator_enable[1])
    rd(8'hE9, v);
    `CHK("alias_rd", 8'h5A, v)
    rd(8'hFC, v);
    `CHK("no_alias", 8'hC0, v)
    @(posedge i_ref_clk);
    i_auto_reload_select <= 1'b0;
    rd(8'hE9, v);
    `CHK("alias_off", 8'h21, v)
    // unmapped read, page deselected, clock held
    rd(8'h80, v);
    `CHK("unmapped", 8'h00, v)
    @(posedge i_ref_clk);
    i_sfr_page_sel <= 1'b0;
    wr(8'hFB, 8'h77);
    `CHK("page_off", 16'hC020, o_capture_value[0])
    @(posedge i_ref_clk);
    i_sfr_page_sel <= 1'b1;
    i_clk_en <= 1'b0;
    wr(8'hFB, 8'h99);
    `CHK("frozen", 16'hC020, o_capture_value[0])
    // enable loaded from the mode path
    @(posedge i_ref_clk);
    i_clk_en <= 1'b1;
    i_ecom_load <= 6'h04;
    i_ecom_value <= 6'h04;
    @(posedge i_ref_clk);
    i_ecom_load <= 6'h00;
    @(negedge i_ref_clk);
    `CHK("ecom_load", 1'b1, o_comparator_enable[2])
    @(posedge i_ref_clk);
    i_ecom_load <= 6'h04;
    i_ecom_value <= 6'h00;
    @(posedge i_ref_clk);
    i_ecom_load <= 6'h00;
    @(negedge i_ref_clk);
    `CHK("ecom_clr", 1'b0, o_comparator_enable[2])
    // second reset in mid-run
    @(posedge i_ref_clk);
    i_arst_n <= 1'b0;
    @(negedge i_ref_clk);
    `CHK("rst_cnt", 16'h0000, o_counter)
    `CHK("rst_cap", 16'h0000, o_capture_value[0])
    `CHK("rst_en", 6'h00, o_comparator_enable)
    @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    rd(8'hFA, v);
    `CHK("rst_snap", 8'h00, v)
    wr(8'hFB, 8'h11);
    `CHK("rst_wr", 16'h0011, o_capture_value[0])
    finish_test();
  end
endmodule : testbench
